/* File: src/bmx_pkg.sv */
// constants shared by the bus multiplexer configuration and switch logic
// Notes on behaviour
// [R1] bits 7/6 set pin direction, 0 output
// [R2] bit 5 zero: connect only high channels
// [R3] bits 4/3: 0 open-drain, 1 push-pull
// [R4] bit 2 enables mass-write address, default on
// [R5] bits 1:0 pick off, 30, 15, 7.5 ms
// [R6] bits 7:4 close channel switches, read back
// [R7] bits 3:0 high when both channel lines high
// [R8] level bit meaningless once channel connected
// [R9] master checks levels before commanding connection
// [R10] any channel subset may connect at once
// [R11] lockout releases pins, ignores bus traffic
// [R12] enable low resets controls, ignores commands
// [R13] channel faults reach alert even when disabled
// [R14] register access only while enable high
// [R15] timeout: alert, buffers off, latch flag
// [R16] refused channel clears connect flag, raises alert
// [R17] buffers on if channels chosen, not stuck
// [R18] offset first, then data written or read
// [R19] timer counts, restarts when both lines high
package bmx_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h00;  // write clears fault flags
  localparam logic [7:0] ADDR_CONFIG    = 8'h02;  // bus_configuration
  localparam logic [7:0] ADDR_SWITCH    = 8'h03;  // channel_switch_and_level
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;  // sticky event status
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h05;  // event mask
  // bus_configuration fields
  localparam int CFG_DIR_ONE = 7;
  localparam int CFG_DIR_TWO = 6;
  localparam int CFG_POLICY  = 5;
  localparam int CFG_DRV_ONE = 4;
  localparam int CFG_DRV_TWO = 3;
  localparam int CFG_MASS_WR = 2;
  localparam int CFG_TMO_HI  = 1;
  localparam int CFG_TMO_LO  = 0;
  localparam logic [7:0] CFG_RESET = 8'h04;  // mass write on, rest zero
  // channel_switch_and_level fields
  localparam int SW_LSB  = 4;
  localparam int NUM_CH  = 4;
  localparam logic [3:0] SW_RESET = 4'h0;  // all switches open
  // timeout selection codes
  localparam logic [1:0] TMO_OFF   = 2'h0;
  localparam logic [1:0] TMO_LONG  = 2'h1;
  localparam logic [1:0] TMO_MID   = 2'h2;
  localparam logic [1:0] TMO_SHORT = 2'h3;
  // interrupt status and mask layout
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_FAULT   = 2;
  localparam int IRQ_W       = 3;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // shared mass-write target address
  localparam logic [6:0] MASS_WRITE_ADDR = 7'h5d;
  // timing
  localparam int CLK_KHZ     = 50_000;
  localparam int T_LONG_US   = 30_000;
  localparam int T_MID_US    = 15_000;
  localparam int T_SHORT_US  = 7_500;
  localparam int LONG_CYC    = T_LONG_US * CLK_KHZ / 1000;
  localparam int MID_CYC     = T_MID_US * CLK_KHZ / 1000;
  localparam int SHORT_CYC   = T_SHORT_US * CLK_KHZ / 1000;
  localparam int CNT_W       = 21;
endpackage

/* File: src/bmx_tmr_if.sv */
// timer control and status between register logic and stuck-low timer
`timescale 1ns/100ps
interface bmx_tmr_if;
  logic [1:0] sel;      // timeout selection
  logic       stuck;    // either monitored line low
  logic       running;  // timeout in effect now
  logic       fire;     // one-cycle pulse at timeout
  modport ctl (output sel, output stuck, input running, input fire);
  modport tmr (input sel, input stuck, output running, output fire);
endinterface

/* File: src/bmx_timer.sv */
// stuck-low timer counting clock cycles to the selected timeout
`timescale 1ns/100ps
module bmx_timer import bmx_pkg::*; #(
  parameter int LONG  = LONG_CYC,
  parameter int MID   = MID_CYC,
  parameter int SHORT = SHORT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control side
  bmx_tmr_if.tmr   tif
);
  logic [CNT_W-1:0] cnt;           // elapsed stuck cycles
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;         // selected timeout in cycles
  logic             running;       // timeout reached
  logic             next_running;
  logic             fire;          // registered pulse
  logic             next_fire;

  // timeout length from the selection code
  function automatic logic [CNT_W-1:0] tmo_limit(input logic [1:0] sel);
    case (sel)
      TMO_LONG:  tmo_limit = CNT_W'(LONG);
      TMO_MID:   tmo_limit = CNT_W'(MID);
      TMO_SHORT: tmo_limit = CNT_W'(SHORT);
      default:   tmo_limit = '0;
    endcase
  endfunction

  // count while stuck, restart when both lines are high
  always_comb begin
    limit        = tmo_limit(tif.sel);  // R5
    next_cnt     = cnt;
    next_running = running;
    if (!tif.stuck || tif.sel == TMO_OFF) begin
      next_cnt     = '0;  // R19
      next_running = 1'b0;
    end else if (cnt >= limit) begin
      next_running = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;  // R19
    end
    next_fire = next_running & ~running;
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= '0;
      running <= 1'b0;
      fire    <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      running <= next_running;
      fire    <= next_fire;
    end
  end

  assign tif.running = running;
  assign tif.fire    = fire;

  // lines high again: counter back to zero
  chk_timer_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tif.stuck |=> cnt == '0 && !running) else $error("timer not restarted"); // R19
  // counter advances by one while stuck and below limit
  chk_timer_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tif.stuck && tif.sel != TMO_OFF && cnt < limit && $stable(tif.sel) |=>
    cnt == $past(cnt) + 1'b1 || !tif.stuck) else $error("timer did not count"); // R19
endmodule

/* File: src/bmx_regs.sv */
// configuration and switch-control registers of the four-channel bus multiplexer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module bmx_regs import bmx_pkg::*; #(
  parameter int TMO_LONG_CYC  = LONG_CYC,
  parameter int TMO_MID_CYC   = MID_CYC,
  parameter int TMO_SHORT_CYC = SHORT_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // supply and enable pins
  input  wire logic       supply_lockout,
  input  wire logic       enable_pin,
  // downstream channel pins
  input  wire logic [3:0] channel_fault_inputs_n,
  input  wire logic [3:0] channel_data_line,
  input  wire logic [3:0] channel_clock_line,
  // monitored common nodes
  input  wire logic       common_data_node,
  input  wire logic       common_clock_node,
  // general pins
  input  wire logic [1:0] pin_drive_state,
  output logic            general_pin_one_out,
  output logic            general_pin_one_oe,
  output logic            general_pin_two_out,
  output logic            general_pin_two_oe,
  // open-drain alert and ready pins
  output logic            alert_out,
  output logic            alert_oe,
  output logic            ready_out,
  output logic            ready_oe,
  // switch and status outputs
  output logic      [3:0] switch_closed,
  output logic            buffers_on,
  output logic            mass_write_enable,
  output logic            timeout_latched,
  output logic            timeout_now,
  output logic            connect_ok,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  ////////////////////////////////////////////////////////////////////////////
  localparam int SYN_W = 16;
  localparam logic [SYN_W-1:0] SYN_IDLE = 16'h3fff;  // pins at rest: lines and faults high
  logic [1:0]       rst_q;       // reset release chain
  logic             rst_n;       // released reset
  logic [SYN_W-1:0] syn_a;       // first stage, read only by syn_b
  logic [SYN_W-1:0] syn_b;       // second stage, safe to use
  logic             lock_s;      // synced lockout
  logic             en_s;        // synced enable
  logic [3:0]       fault_n_s;   // synced channel faults
  logic [3:0]       ch_level;    // both channel lines high
  logic             stuck_s;     // common node low
  logic             active;      // accepting commands
  // two-stage reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  // two-flop synchroniser for the lockout, enable, channel and node pins, reset to rest levels so no false fault
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syn_a <= SYN_IDLE;
      syn_b <= SYN_IDLE;
    end else begin
      syn_a <= {supply_lockout, enable_pin, channel_fault_inputs_n,
                channel_data_line, channel_clock_line,
                common_data_node, common_clock_node};
      syn_b <= syn_a;
    end
  end
  assign lock_s    = syn_b[15];
  assign en_s      = syn_b[14];
  assign fault_n_s = syn_b[13:10];
  assign ch_level  = syn_b[9:6] & syn_b[5:2];  // R7
  assign stuck_s   = ~(syn_b[1] & syn_b[0]);
  assign active    = en_s & ~lock_s;  // R12 R14
  ////////////////////////////////////////////////////////////////////////////
  // stuck-low timer
  ////////////////////////////////////////////////////////////////////////////
  bmx_tmr_if tif ();
  bmx_timer #(
    .LONG  (TMO_LONG_CYC),
    .MID   (TMO_MID_CYC),
    .SHORT (TMO_SHORT_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tif     (tif)
  );
  ////////////////////////////////////////////////////////////////////////////
  // register state
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]       cfg;          // bus_configuration
  logic [7:0]       next_cfg;
  logic [3:0]       sw;           // channel switch bits
  logic [3:0]       next_sw;
  logic             buf_on;       // buffers active
  logic             next_buf_on;
  logic             tmo_latch;    // latched timeout
  logic             next_tmo_latch;
  logic             conn_ok;      // no refused connection
  logic             next_conn_ok;
  logic [IRQ_W-1:0] stat;         // sticky events
  logic [IRQ_W-1:0] next_stat;
  logic [IRQ_W-1:0] mask;         // event mask
  logic [IRQ_W-1:0] next_mask;
  logic [IRQ_W-1:0] events;       // this cycle's events
  logic             wr_cfg;       // write decode strobes
  logic             wr_sw;
  logic             wr_clr;
  logic             wr_stat;
  logic             wr_mask;
  logic [3:0]       cmd;          // commanded channels
  logic             refused;      // commanded channel low
  logic             fault_any;    // any channel fault low
  // offset decode of writes, only while active
  always_comb begin
    wr_cfg  = reg_wr && active && reg_addr == ADDR_CONFIG;  // R18 R14
    wr_sw   = reg_wr && active && reg_addr == ADDR_SWITCH;
    wr_clr  = reg_wr && active && reg_addr == ADDR_FAULT_CLR;
    wr_stat = reg_wr && active && reg_addr == ADDR_IRQ_STAT;
    wr_mask = reg_wr && active && reg_addr == ADDR_IRQ_MASK;
  end
  // next values of configuration, switches and flags
  always_comb begin
    cmd            = reg_wdata[7:SW_LSB];
    refused        = wr_sw && !cfg[CFG_POLICY] && |(cmd & ~ch_level);  // R16
    fault_any      = ~&fault_n_s;
    next_cfg       = cfg;
    next_sw        = sw;
    next_buf_on    = buf_on;
    next_tmo_latch = tmo_latch;
    next_conn_ok   = conn_ok;
    next_mask      = mask;
    // configuration write
    if (wr_cfg) begin
      next_cfg = reg_wdata;  // R1 R3 R4 R5
    end
    // connection command
    if (wr_sw) begin
      if (cfg[CFG_POLICY]) begin
        next_sw = cmd;  // R2 R10
      end else begin
        next_sw = cmd & ch_level;  // R2
      end
      next_buf_on = |next_sw && !tif.running;  // R17
    end
    // fault flag clear, a new event wins
    if (wr_clr) begin
      next_tmo_latch = 1'b0;
      next_conn_ok   = 1'b1;
    end
    // timeout: latch set, buffers off, switches kept
    if (tif.fire) begin
      next_buf_on    = 1'b0;  // R15
      next_tmo_latch = 1'b1;  // R15
    end
    if (refused) begin
      next_conn_ok = 1'b0;  // R16
    end
    if (wr_mask) begin
      next_mask = reg_wdata[IRQ_W-1:0];
    end
    // disabled or locked out: defaults held
    if (!active) begin
      next_cfg       = CFG_RESET;  // R12
      next_sw        = SW_RESET;   // R12
      next_buf_on    = 1'b0;
      next_tmo_latch = 1'b0;
      next_conn_ok   = 1'b1;
      next_mask      = MASK_RESET;
    end
  end
  // sticky event bits, set wins over write-one clear
  always_comb begin
    events              = '0;
    events[IRQ_TIMEOUT] = tif.fire && active;
    events[IRQ_REFUSED] = refused;
    events[IRQ_FAULT]   = fault_any && active;
    // write-one clear first, this cycle's events on top
    next_stat           = (stat & ~({IRQ_W{wr_stat}} & reg_wdata[IRQ_W-1:0])) | events;
    if (!active) begin
      next_stat = '0;
    end
  end
  // register state flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= CFG_RESET;
      sw        <= SW_RESET;
      buf_on    <= 1'b0;
      tmo_latch <= 1'b0;
      conn_ok   <= 1'b1;
      stat      <= '0;
      mask      <= MASK_RESET;
    end else begin
      cfg       <= next_cfg;
      sw        <= next_sw;
      buf_on    <= next_buf_on;
      tmo_latch <= next_tmo_latch;
      conn_ok   <= next_conn_ok;
      stat      <= next_stat;
      mask      <= next_mask;
    end
  end
  assign tif.sel   = cfg[CFG_TMO_HI:CFG_TMO_LO];  // R5
  assign tif.stuck = stuck_s;
  ////////////////////////////////////////////////////////////////////////////
  // pins and read data
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] next_rdata;   // read data for next cycle
  logic       next_alert;   // pull alert low
  logic       next_ready;   // pull ready low
  logic [1:0] next_gp_out;  // general pin levels
  logic [1:0] next_gp_oe;   // general pin enables
  logic       next_irq;
  logic       next_tnow;
  logic [1:0] gp_out;
  logic [1:0] gp_oe;
  logic       tnow;
  // read mux, zero when idle or disabled
  always_comb begin
    next_rdata = '0;
    if (reg_rd && active) begin  // R14 R18
      case (reg_addr)
        ADDR_CONFIG:   next_rdata = cfg;
        ADDR_SWITCH:   next_rdata = {sw, ch_level};  // R6 R7 R8
        ADDR_IRQ_STAT: next_rdata = 8'(stat);
        ADDR_IRQ_MASK: next_rdata = 8'(mask);
        default:       next_rdata = '0;
      endcase
    end
  end
  // alert, ready, general pins and interrupt
  always_comb begin
    next_alert  = !lock_s && (fault_any || next_tmo_latch || !next_conn_ok);  // R13 R11
    next_ready  = !lock_s && !next_buf_on;  // R17
    next_irq    = |(next_stat & next_mask);
    next_tnow   = tif.running;
    next_gp_out = '0;
    next_gp_oe  = '0;
    // output mode: push-pull drives level, open-drain only pulls low
    if (!lock_s) begin  // R11
      if (!next_cfg[CFG_DIR_ONE]) begin  // R1
        next_gp_out[0] = next_cfg[CFG_DRV_ONE] & pin_drive_state[0];  // R3
        next_gp_oe[0]  = next_cfg[CFG_DRV_ONE] | ~pin_drive_state[0];
      end
      if (!next_cfg[CFG_DIR_TWO]) begin  // R1
        next_gp_out[1] = next_cfg[CFG_DRV_TWO] & pin_drive_state[1];  // R3
        next_gp_oe[1]  = next_cfg[CFG_DRV_TWO] | ~pin_drive_state[1];
      end
    end
  end
  // output flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      alert_oe  <= 1'b0;
      ready_oe  <= 1'b0;
      irq       <= 1'b0;
      tnow      <= 1'b0;
      gp_out    <= '0;
      gp_oe     <= '0;
      alert_out <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      alert_oe  <= next_alert;
      ready_oe  <= next_ready;
      irq       <= next_irq;
      tnow      <= next_tnow;
      gp_out    <= next_gp_out;
      gp_oe     <= next_gp_oe;
      alert_out <= 1'b0;  // open drain only pulls low
      ready_out <= 1'b0;
    end
  end
  assign general_pin_one_out = gp_out[0];
  assign general_pin_one_oe  = gp_oe[0];
  assign general_pin_two_out = gp_out[1];
  assign general_pin_two_oe  = gp_oe[1];
  assign switch_closed       = sw;
  assign buffers_on          = buf_on;
  assign mass_write_enable   = cfg[CFG_MASS_WR];  // R4
  assign timeout_latched     = tmo_latch;
  assign timeout_now         = tnow;
  assign connect_ok          = conn_ok;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence sw_write_seq;
    wr_sw && !tif.running && !tif.fire;
  endsequence
  sequence fire_seq;
    tif.fire && active;
  endsequence
  chk_cfg_write: assert property (wr_cfg && active |=> !active || cfg == $past(reg_wdata)) // R1
    else $error("config write lost");
  chk_policy_gate: assert property (wr_sw && !cfg[CFG_POLICY] |=>
    (sw & ~$past(ch_level)) == 4'h0) else $error("low channel connected"); // R2
  chk_open_drain: assert property ($past(!lock_s && !next_cfg[CFG_DIR_ONE]
    && !next_cfg[CFG_DRV_ONE]) |-> !general_pin_one_out) else $error("drive high"); // R3
  chk_mass_default: assert property (!active |=> mass_write_enable) // R4
    else $error("mass write not default");
  chk_subset_any: assert property (wr_sw && cfg[CFG_POLICY] && active |=>
    sw == $past(reg_wdata[7:4])) else $error("subset not taken"); // R10
  chk_switch_read: assert property (reg_rd && active && reg_addr == ADDR_SWITCH |=>
    reg_rdata == {$past(sw), $past(ch_level)}) else $error("switch read"); // R6
  chk_lockout_quiet: assert property (lock_s |=> !alert_oe && gp_oe == 2'h0) // R11
    else $error("pins driven in lockout");
  chk_enable_clear: assert property (!en_s |=> cfg == CFG_RESET && sw == SW_RESET) // R12
    else $error("controls kept");
  chk_alert_follow: assert property (!lock_s && fault_any |=> alert_oe) // R13
    else $error("fault not forwarded");
  chk_disabled_read: assert property (reg_rd && !active |=> reg_rdata == 8'h00) // R14
    else $error("read while disabled");
  chk_timeout_effect: assert property (fire_seq |=> !buffers_on && timeout_latched
    && alert_oe && sw == $past(sw)) else $error("timeout effect"); // R15
  chk_refuse_flag: assert property (refused |=> !connect_ok && alert_oe) // R16
    else $error("refusal not flagged");
  chk_ready_release: assert property (sw_write_seq ##0 (|next_sw) |=>
    buffers_on && !ready_oe) else $error("buffers not active"); // R17
endmodule

/* File: verification/bmx_chan_model.sv */
// downstream channels and common nodes as seen by the mux
`timescale 1ns/100ps
module bmx_chan_model (
  // test controls
  input  wire logic [3:0] data_low,
  input  wire logic [3:0] clk_low,
  input  wire logic [3:0] fault_mask,
  input  wire logic       stuck,
  input  wire logic       traffic,
  // lines seen by the mux
  output logic      [3:0] data_line,
  output logic      [3:0] clock_line,
  output logic      [3:0] fault_n,
  output logic            node_data,
  output logic            node_clock
);
  logic link_clk = 1'b1;  // idle high between frames
  // 160 ns link clock, only inside a frame
  always #80 link_clk = traffic ? ~link_clk : 1'b1;
  // pulled-up lines, low only where a channel holds them
  assign data_line  = ~data_low;
  assign clock_line = ~clk_low;
  assign fault_n    = ~fault_mask;
  assign node_data  = ~stuck;
  assign node_clock = link_clk;
endmodule

/* File: verification/test_bmx_regs.sv */
// self-checking bench for the mux configuration and switch registers
`timescale 1ns/100ps
module test_bmx_regs import bmx_pkg::*;;
  localparam int LIM [4] = '{0, 40, 20, 10};  // shortened timeouts
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       supply_lockout = 1'b0;
  logic       enable_pin = 1'b1;
  logic [3:0] fault_n, dline, cline;
  logic       cdata, cclk;
  logic [1:0] pin_drive_state = 2'h1;
  logic       p1_out, p1_oe, p2_out, p2_oe, alert_out, alert_oe, ready_out, ready_oe;
  logic [3:0] switch_closed;
  logic       buffers_on, mass_write_enable, timeout_latched, timeout_now, connect_ok, irq;
  logic [3:0] data_low = 4'h0;
  logic [3:0] clk_low = 4'h0;
  logic [3:0] fault_mask = 4'h0;
  logic       stuck = 1'b0;
  logic       traffic = 1'b0;
  int         fail_count = 0;
  int         checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  bmx_regs #(.TMO_LONG_CYC(40), .TMO_MID_CYC(20), .TMO_SHORT_CYC(10)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_lockout(supply_lockout), .enable_pin(enable_pin),
    .channel_fault_inputs_n(fault_n), .channel_data_line(dline),
    .channel_clock_line(cline), .common_data_node(cdata), .common_clock_node(cclk),
    .pin_drive_state(pin_drive_state), .general_pin_one_out(p1_out),
    .general_pin_one_oe(p1_oe), .general_pin_two_out(p2_out), .general_pin_two_oe(p2_oe),
    .alert_out(alert_out), .alert_oe(alert_oe), .ready_out(ready_out), .ready_oe(ready_oe),
    .switch_closed(switch_closed), .buffers_on(buffers_on),
    .mass_write_enable(mass_write_enable), .timeout_latched(timeout_latched),
    .timeout_now(timeout_now), .connect_ok(connect_ok), .irq(irq));
  bmx_chan_model chan (
    .data_low(data_low), .clk_low(clk_low), .fault_mask(fault_mask), .stuck(stuck),
    .traffic(traffic), .data_line(dline), .clock_line(cline), .fault_n(fault_n),
    .node_data(cdata), .node_clock(cclk));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // wait cycles, then step past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // one-cycle read, data taken in the following cycle, masked compare
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] msk);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata & msk, exp);
  endtask
  // stuck node until timeout, delay must fit the selected limit
  task automatic fire(input int code);
    int n;
    n = 0;
    wr(ADDR_CONFIG, {6'h08, code[1:0]});
    stuck <= 1'b1;
    cyc(1);
    while (timeout_now !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("tmo delay", {7'h0, n > LIM[code] && n <= LIM[code] + 8}, 8'h01);
    check("tmo effect", {buffers_on, timeout_latched, alert_oe, switch_closed}, 8'h3f);
    rchk("tmo stat", ADDR_IRQ_STAT, 8'h01, 8'h01);
    stuck <= 1'b0;
    cyc(6);
    check("tmo kept", {timeout_now, timeout_latched}, 8'h01);
    wr(ADDR_FAULT_CLR, 8'h00);
    cyc(3);
    check("tmo clr", {timeout_latched, alert_oe}, 8'h00);
  endtask
  // closing report
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    cyc(2);
    arst_n <= 1'b1;
    cyc(8);
    rchk("cfg rst", ADDR_CONFIG, CFG_RESET, 8'hff);
    rchk("sw rst", ADDR_SWITCH, 8'h0f, 8'hff);
    check("mass rst", mass_write_enable, 8'h01);
    rchk("unmapped", 8'h7e, 8'h00, 8'hff);
    wr(ADDR_CONFIG, 8'hff);
    rchk("cfg all", ADDR_CONFIG, 8'hff, 8'hff);
    cyc(1);
    check("rd idle", reg_rdata, 8'h00);
    wr(ADDR_CONFIG, 8'h18);
    cyc(3);
    check("push pull", {p1_out, p1_oe, p2_out, p2_oe}, 8'h0d);
    wr(ADDR_CONFIG, 8'h00);
    cyc(3);
    check("open drain", {p1_out, p1_oe, p2_out, p2_oe, mass_write_enable}, 8'h02);
    wr(ADDR_CONFIG, 8'hc0);
    cyc(3);
    check("input mode", {p1_oe, p2_oe}, 8'h00);
    // channel 2 data low, channel 0 clock low, refused under policy 0
    data_low <= 4'h4;
    clk_low  <= 4'h1;
    wr(ADDR_CONFIG, 8'h00);
    cyc(4);
    rchk("levels", ADDR_SWITCH, 8'h0a, 8'hff);
    wr(ADDR_SWITCH, 8'hf0);
    cyc(2);
    check("refused", {switch_closed, connect_ok, alert_oe}, 8'h29);
    check("od level", {alert_out, ready_out}, 8'h00);
    check("buf on", {buffers_on, ready_oe}, 8'h02);
    rchk("sw read", ADDR_SWITCH, 8'ha0, 8'hf0);
    rchk("status", ADDR_IRQ_STAT, 8'h02, 8'h07);
    check("irq masked", irq, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h02);
    cyc(2);
    rchk("mask", ADDR_IRQ_MASK, 8'h02, 8'hff);
    check("irq on", irq, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_FAULT_CLR, 8'h00);
    cyc(3);
    check("irq clr", {irq, connect_ok, alert_oe}, 8'h02);
    wr(ADDR_SWITCH, 8'h00);
    cyc(2);
    check("buf off", {switch_closed, buffers_on, ready_oe}, 8'h01);
    wr(ADDR_CONFIG, 8'h20);
    wr(ADDR_SWITCH, 8'hf0);
    cyc(2);
    check("forced", {switch_closed, connect_ok}, 8'h1f);
    data_low <= 4'h0;
    clk_low  <= 4'h0;
    for (int c = 3; c > 0; c--) fire(c);
    wr(ADDR_CONFIG, 8'h20);
    stuck <= 1'b1;
    cyc(100);
    check("tmo off", timeout_now, 8'h00);
    stuck <= 1'b0;
    wr(ADDR_CONFIG, 8'h23);
    traffic <= 1'b1;
    cyc(200);
    check("traffic", {timeout_now, timeout_latched}, 8'h00);
    traffic <= 1'b0;
    // channel fault, then disable
    fault_mask <= 4'h2;
    cyc(5);
    check("fault", alert_oe, 8'h01);
    rchk("fault stat", ADDR_IRQ_STAT, 8'h04, 8'h04);
    enable_pin <= 1'b0;
    cyc(6);
    check("disabled", {switch_closed, mass_write_enable, alert_oe}, 8'h03);
    rchk("dis read", ADDR_CONFIG, 8'h00, 8'hff);
    wr(ADDR_CONFIG, 8'hff);
    enable_pin <= 1'b1;
    cyc(6);
    rchk("dis write", ADDR_CONFIG, CFG_RESET, 8'hff);
    wr(ADDR_CONFIG, 8'h18);
    supply_lockout <= 1'b1;
    cyc(6);
    check("lockout", {p1_oe, p2_oe, alert_oe}, 8'h00);
    rchk("lock read", ADDR_CONFIG, 8'h00, 8'hff);
    print_verdict();
  end
endmodule
